// *** src/rssim_pkg.sv ***
//------------------------------------------------------------
//------------------------------------------------------------
package rssim_pkg;

	//------------------------------------------------------------
	// widths
	//------------------------------------------------------------
	localparam int ADDR_W  = 4;
	localparam int DATA_W  = 8;
	localparam int LEVEL_W = 8;
	localparam int WIN_LEN = 16;
	localparam int WIN_LOG = 4;
	localparam int SUM_W   = LEVEL_W + WIN_LOG;
	localparam int ACC_W   = 18;

	//------------------------------------------------------------
	// register offsets
	//------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_MODE  = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_FILT  = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_CPLX  = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_DEV   = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_LEVEL = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_IRQ   = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_RSSI  = 4'h6;

	//------------------------------------------------------------
	// field positions
	//------------------------------------------------------------
	localparam int MODE_LSB = 5;
	localparam int GAIN_LSB = 3;
	localparam int PBW_LSB  = 4;
	localparam int LPF_LSB  = 0;
	localparam int CPX_BIT  = 7;
	localparam int CEN_LSB  = 3;
	localparam int SRCA_LSB = 6;
	localparam int SRCB_LSB = 4;
	localparam int FLAG_BIT = 0;

	//------------------------------------------------------------
	// codes and reset values
	//------------------------------------------------------------
	typedef enum logic [1:0] {
		GAIN_M13P5, GAIN_M9, GAIN_M4P5, GAIN_0DB
	} rssim_gain_t;

	typedef enum logic [1:0] {MS_IDLE, MS_FILL, MS_RUN} rssim_meas_t;

	localparam logic [2:0]         MODE_RX    = 3'h3;
	localparam logic [2:0]         MODE_RST   = 3'h0;
	localparam logic [3:0]         PBW_RST    = 4'h0;
	localparam logic [3:0]         LPF_RST    = 4'h0;
	localparam logic [3:0]         CEN_RST    = 4'h3;
	localparam logic [7:0]         DEV_RST    = 8'h03;
	localparam logic [7:0]         LEVEL_RST  = 8'h00;
	localparam logic [1:0]         SRC_RST    = 2'h0;
	localparam logic [1:0]         SRC_ALARM  = 2'h1;
	localparam logic [DATA_W-1:0]  RD_UNMAP   = 8'h00;

	//------------------------------------------------------------
	// timing
	//------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int CLK_KHZ       = 1000000 / CLK_PERIOD_NS;
	localparam int FDEV_STEP_KHZ = 25;
	localparam int SAMPLES_PER   = 16;
	localparam logic [ACC_W-1:0] ACC_WRAP = ACC_W'(CLK_KHZ);

	// phase step per clock: sixteen samples per deviation period
	function automatic logic [ACC_W-1:0] rate_inc(input logic [7:0] dev);
		logic [ACC_W-1:0] d;
		d = ACC_W'(dev) + ACC_W'(1);
		return ACC_W'(d * ACC_W'(SAMPLES_PER * FDEV_STEP_KHZ));
	endfunction : rate_inc

	// envelope sample: larger of the i and q levels
	function automatic logic [LEVEL_W-1:0] env_of(
		input logic [LEVEL_W-1:0] a,
		input logic [LEVEL_W-1:0] b
	);
		return (a > b) ? a : b;
	endfunction : env_of

endpackage : rssim_pkg

// *** src/rssim_avg_if.sv ***
interface rssim_avg_if;
	import rssim_pkg::*;

	logic               clear;
	logic               sample_stb;
	logic [LEVEL_W-1:0] sample;
	logic               update;
	logic [LEVEL_W-1:0] mean;

	modport meter (output clear, output sample_stb, output sample,
		input update, input mean);
	modport avg (input clear, input sample_stb, input sample,
		output update, output mean);
endinterface : rssim_avg_if

// *** src/rssim_avg.sv ***
module rssim_avg
	import rssim_pkg::*;
(
	// clock and reset
	input  wire logic   clk,
	input  wire logic   reset_n,
	// sample stream
	rssim_avg_if.avg    bus
);

	//------------------------------------------------------------
	// sliding window
	//------------------------------------------------------------
	logic [LEVEL_W-1:0] win [WIN_LEN];
	logic [WIN_LOG-1:0] ptr;
	logic [SUM_W-1:0]   sum;
	logic [SUM_W-1:0]   next_sum;

	// oldest sample leaves as the new one enters
	assign next_sum = sum + SUM_W'(bus.sample) - SUM_W'(win[ptr]);

	always_ff @(posedge clk) begin
		if (!reset_n || bus.clear) begin
			for (int k = 0; k < WIN_LEN; k++) begin
				win[k] <= '0;
			end
			ptr <= '0;
			sum <= '0;
		end else if (bus.sample_stb) begin
			win[ptr] <= bus.sample;
			ptr      <= ptr + WIN_LOG'(1);
			sum      <= next_sum;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n || bus.clear) begin
			bus.mean   <= '0;
			bus.update <= 1'b0;
		end else begin
			bus.update <= bus.sample_stb;
			if (bus.sample_stb) begin
				bus.mean <= next_sum[SUM_W-1:WIN_LOG];
			end
		end
	end

endmodule : rssim_avg

// *** src/rssim_top.sv ***
module rssim_top
	import rssim_pkg::*;
(
	// clock and reset
	input  wire logic              SYS_CLK,
	input  wire logic              RESET_N,
	// register port
	input  wire logic [ADDR_W-1:0] ADDR,
	input  wire logic [DATA_W-1:0] WDATA,
	input  wire logic              WR,
	input  wire logic              RD,
	output logic      [DATA_W-1:0] RDATA,
	// baseband levels from the amplifier chain
	input  wire logic [LEVEL_W-1:0] I_LEVEL,
	input  wire logic [LEVEL_W-1:0] Q_LEVEL,
	// receive chain configuration
	output logic      [1:0]        IF_GAIN_SEL,
	output logic      [3:0]        PASSIVE_BW_SEL,
	output logic      [3:0]        LOWPASS_CUTOFF_SEL,
	output logic                   COMPLEX_FILTER_EN,
	output logic      [3:0]        COMPLEX_CENTER_SEL,
	output logic      [2:0]        OPERATING_MODE_SEL,
	// measurement and events
	output logic      [LEVEL_W-1:0] SIGNAL_STRENGTH_VALUE,
	output logic                   EVENT_PIN_A,
	output logic                   EVENT_PIN_B
);

	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	logic [2:0]         operating_mode_sel;
	rssim_gain_t        if_gain_sel;
	logic [3:0]         passive_bw_sel;
	logic [3:0]         lowpass_cutoff_sel;
	logic               complex_filter_en;
	logic [3:0]         complex_center_sel;
	logic [7:0]         deviation_setting;
	logic [7:0]         strength_alarm_level;
	logic [1:0]         pin_a_source_sel;
	logic [1:0]         pin_b_source_sel;
	logic               strength_alarm_flag;
	logic [LEVEL_W-1:0] signal_strength_value;

	//------------------------------------------------------------
	// address decode
	//------------------------------------------------------------
	logic wr_mode;
	logic wr_filt;
	logic wr_cplx;
	logic wr_dev;
	logic wr_level;
	logic wr_irq;
	logic flag_clear;

	assign wr_mode  = WR && (ADDR == OFS_MODE);
	assign wr_filt  = WR && (ADDR == OFS_FILT);
	assign wr_cplx  = WR && (ADDR == OFS_CPLX);
	assign wr_dev   = WR && (ADDR == OFS_DEV);
	assign wr_level = WR && (ADDR == OFS_LEVEL);
	assign wr_irq   = WR && (ADDR == OFS_IRQ);
	assign flag_clear = wr_irq && WDATA[FLAG_BIT];

	//------------------------------------------------------------
	// register writes
	//------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			operating_mode_sel <= MODE_RST;
			if_gain_sel        <= GAIN_0DB;
		end else if (wr_mode) begin
			operating_mode_sel <= WDATA[MODE_LSB +: 3];
			if_gain_sel        <= rssim_gain_t'(WDATA[GAIN_LSB +: 2]);
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			passive_bw_sel     <= PBW_RST;
			lowpass_cutoff_sel <= LPF_RST;
		end else if (wr_filt) begin
			passive_bw_sel     <= WDATA[PBW_LSB +: 4];
			lowpass_cutoff_sel <= WDATA[LPF_LSB +: 4];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			complex_filter_en  <= 1'b0;
			complex_center_sel <= CEN_RST;
		end else if (wr_cplx) begin
			complex_filter_en  <= WDATA[CPX_BIT];
			complex_center_sel <= WDATA[CEN_LSB +: 4];
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			deviation_setting <= DEV_RST;
		end else if (wr_dev) begin
			deviation_setting <= WDATA;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			strength_alarm_level <= LEVEL_RST;
		end else if (wr_level) begin
			strength_alarm_level <= WDATA;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			pin_a_source_sel <= SRC_RST;
			pin_b_source_sel <= SRC_RST;
		end else if (wr_irq) begin
			pin_a_source_sel <= WDATA[SRCA_LSB +: 2];
			pin_b_source_sel <= WDATA[SRCB_LSB +: 2];
		end
	end

	//------------------------------------------------------------
	// level input synchronisers
	//------------------------------------------------------------
	logic [LEVEL_W-1:0] i_meta;
	logic [LEVEL_W-1:0] i_sync;
	logic [LEVEL_W-1:0] q_meta;
	logic [LEVEL_W-1:0] q_sync;

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			i_meta <= '0;
			i_sync <= '0;
			q_meta <= '0;
			q_sync <= '0;
		end else begin
			i_meta <= I_LEVEL;
			i_sync <= i_meta;
			q_meta <= Q_LEVEL;
			q_sync <= q_meta;
		end
	end

	//------------------------------------------------------------
	// sample rate generator
	//------------------------------------------------------------
	logic             rx_on;
	logic [ACC_W-1:0] acc;
	logic [ACC_W-1:0] inc;
	logic [ACC_W-1:0] next_acc;
	logic             rate_max;
	logic             wrap;
	logic             sample_stb;

	// nothing is measured outside receive mode
	assign rx_on    = (operating_mode_sel == MODE_RX);
	// one rate for both modes: in ook the deviation equals the low if
	assign inc      = rate_inc(deviation_setting);
	assign next_acc = acc + inc;
	assign rate_max = (inc >= ACC_WRAP);
	assign wrap     = rate_max || (next_acc >= ACC_WRAP);

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N || !rx_on || rate_max) begin
			acc <= '0;
		end else if (wrap) begin
			acc <= next_acc - ACC_WRAP;
		end else begin
			acc <= next_acc;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			sample_stb <= 1'b0;
		end else begin
			sample_stb <= rx_on && wrap;
		end
	end

	//------------------------------------------------------------
	// averager
	//------------------------------------------------------------
	rssim_avg_if avg_bus ();

	assign avg_bus.clear      = !rx_on;
	assign avg_bus.sample_stb = sample_stb;
	assign avg_bus.sample     = env_of(i_sync, q_sync);

	rssim_avg u_avg (
		.clk     (SYS_CLK),
		.reset_n (RESET_N),
		.bus     (avg_bus.avg)
	);

	//------------------------------------------------------------
	// measurement state
	//------------------------------------------------------------
	rssim_meas_t        meas;
	rssim_meas_t        next_meas;
	logic [WIN_LOG-1:0] fill_cnt;
	logic               fill_done;

	assign fill_done = avg_bus.update && (fill_cnt == WIN_LOG'(WIN_LEN - 1));

	always_comb begin
		next_meas = meas;
		case (meas)
			MS_IDLE: begin
				if (rx_on) begin
					next_meas = MS_FILL;
				end
			end
			MS_FILL: begin
				if (!rx_on) begin
					next_meas = MS_IDLE;
				end else if (fill_done) begin
					next_meas = MS_RUN;
				end
			end
			MS_RUN: begin
				if (!rx_on) begin
					next_meas = MS_IDLE;
				end
			end
			default: begin
				next_meas = MS_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			meas     <= MS_IDLE;
			fill_cnt <= '0;
		end else begin
			meas <= next_meas;
			if (meas != MS_FILL) begin
				fill_cnt <= '0;
			end else if (avg_bus.update) begin
				fill_cnt <= fill_cnt + WIN_LOG'(1);
			end
		end
	end

	//------------------------------------------------------------
	// strength value and alarm
	//------------------------------------------------------------
	logic above;
	logic alarm_set;

	assign above     = (avg_bus.mean > strength_alarm_level);
	assign alarm_set = (meas == MS_RUN) && avg_bus.update && above;

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			signal_strength_value <= '0;
		end else if (avg_bus.update) begin
			signal_strength_value <= avg_bus.mean;
		end
	end

	// a new event wins over a clear in the same cycle
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			strength_alarm_flag <= 1'b0;
		end else if (alarm_set) begin
			strength_alarm_flag <= 1'b1;
		end else if (flag_clear) begin
			strength_alarm_flag <= 1'b0;
		end
	end

	//------------------------------------------------------------
	// event pins
	//------------------------------------------------------------
	logic pin_a_next;
	logic pin_b_next;

	assign pin_a_next = (pin_a_source_sel == SRC_ALARM) &&
		strength_alarm_flag;
	assign pin_b_next = (pin_b_source_sel == SRC_ALARM) &&
		strength_alarm_flag;

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			EVENT_PIN_A <= 1'b0;
			EVENT_PIN_B <= 1'b0;
		end else begin
			EVENT_PIN_A <= pin_a_next;
			EVENT_PIN_B <= pin_b_next;
		end
	end

	//------------------------------------------------------------
	// read back
	//------------------------------------------------------------
	logic [DATA_W-1:0] rd_word;

	always_comb begin
		rd_word = RD_UNMAP;
		if (ADDR == OFS_MODE) begin
			rd_word[MODE_LSB +: 3] = operating_mode_sel;
			rd_word[GAIN_LSB +: 2] = if_gain_sel;
		end else if (ADDR == OFS_FILT) begin
			rd_word[PBW_LSB +: 4] = passive_bw_sel;
			rd_word[LPF_LSB +: 4] = lowpass_cutoff_sel;
		end else if (ADDR == OFS_CPLX) begin
			rd_word[CPX_BIT]      = complex_filter_en;
			rd_word[CEN_LSB +: 4] = complex_center_sel;
		end else if (ADDR == OFS_DEV) begin
			rd_word = deviation_setting;
		end else if (ADDR == OFS_LEVEL) begin
			rd_word = strength_alarm_level;
		end else if (ADDR == OFS_IRQ) begin
			rd_word[SRCA_LSB +: 2] = pin_a_source_sel;
			rd_word[SRCB_LSB +: 2] = pin_b_source_sel;
			rd_word[FLAG_BIT]      = strength_alarm_flag;
		end else if (ADDR == OFS_RSSI) begin
			rd_word = signal_strength_value;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			RDATA <= '0;
		end else if (RD) begin
			RDATA <= rd_word;
		end else begin
			RDATA <= '0;
		end
	end

	//------------------------------------------------------------
	// configuration and strength outputs
	//------------------------------------------------------------
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			IF_GAIN_SEL           <= GAIN_0DB;
			PASSIVE_BW_SEL        <= PBW_RST;
			LOWPASS_CUTOFF_SEL    <= LPF_RST;
			COMPLEX_FILTER_EN     <= 1'b0;
			COMPLEX_CENTER_SEL    <= CEN_RST;
			OPERATING_MODE_SEL    <= MODE_RST;
			SIGNAL_STRENGTH_VALUE <= '0;
		end else begin
			IF_GAIN_SEL           <= if_gain_sel;
			PASSIVE_BW_SEL        <= passive_bw_sel;
			LOWPASS_CUTOFF_SEL    <= lowpass_cutoff_sel;
			COMPLEX_FILTER_EN     <= complex_filter_en;
			COMPLEX_CENTER_SEL    <= complex_center_sel;
			OPERATING_MODE_SEL    <= operating_mode_sel;
			SIGNAL_STRENGTH_VALUE <= signal_strength_value;
		end
	end

endmodule : rssim_top

// *** dv/rssim_checker.sv ***
module rssim_checker
	import rssim_pkg::*;
(
	// clock and reset
	input wire logic                SYS_CLK,
	input wire logic                RESET_N,
	// register port
	input wire logic [ADDR_W-1:0]   ADDR,
	input wire logic [DATA_W-1:0]   WDATA,
	input wire logic                WR,
	input wire logic                RD,
	input wire logic [DATA_W-1:0]   RDATA,
	// configuration, strength value and events
	input wire logic [1:0]          IF_GAIN_SEL,
	input wire logic [3:0]          PASSIVE_BW_SEL,
	input wire logic [3:0]          LOWPASS_CUTOFF_SEL,
	input wire logic                COMPLEX_FILTER_EN,
	input wire logic [3:0]          COMPLEX_CENTER_SEL,
	input wire logic [LEVEL_W-1:0]  SIGNAL_STRENGTH_VALUE,
	input wire logic                EVENT_PIN_A,
	input wire logic                EVENT_PIN_B
);
	timeunit 1ns;
	timeprecision 1ps;

	logic       irq_wr;
	logic [1:0] wr_gain;
	logic       wr_cpx;
	logic [1:0] src_a;
	logic [1:0] src_b;
	logic [7:0] lvl;

	assign irq_wr  = WR && (ADDR == OFS_IRQ);
	assign wr_gain = WDATA[GAIN_LSB+:2];
	assign wr_cpx  = WDATA[CPX_BIT];

	// shadow of the routing and alarm level registers
	always_ff @(posedge SYS_CLK) begin
		if (!RESET_N) begin
			src_a <= SRC_RST;
			src_b <= SRC_RST;
			lvl   <= LEVEL_RST;
		end else begin
			if (irq_wr) begin
				src_a <= WDATA[SRCA_LSB+:2];
				src_b <= WDATA[SRCB_LSB+:2];
			end
			if (WR && (ADDR == OFS_LEVEL)) begin
				lvl <= WDATA;
			end
		end
	end

	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	sequence s_wr(logic [ADDR_W-1:0] a);
		WR && (ADDR == a);
	endsequence
	sequence s_rd(logic [ADDR_W-1:0] a);
		RD && (ADDR == a);
	endsequence
	sequence s_hold_a;
		EVENT_PIN_A [*2];
	endsequence

	AST_RST_VALUES: assert property ($rose(RESET_N) |->
		IF_GAIN_SEL == GAIN_0DB && COMPLEX_CENTER_SEL == CEN_RST)
		else $error("config output not at reset value");
	AST_GAIN: assert property (s_wr(OFS_MODE) |->
		##2 IF_GAIN_SEL == $past(wr_gain, 2))
		else $error("gain output does not follow write");
	AST_CPLX: assert property (s_wr(OFS_CPLX) |->
		##2 COMPLEX_FILTER_EN == $past(wr_cpx, 2))
		else $error("filter enable does not follow write");
	AST_FILT: assert property (s_wr(OFS_FILT) |-> ##2
		{PASSIVE_BW_SEL, LOWPASS_CUTOFF_SEL} == $past(WDATA, 2))
		else $error("filter fields do not follow write");
	AST_PIN_A_SRC: assert property (EVENT_PIN_A |->
		$past(src_a) == SRC_ALARM)
		else $error("pin a active without alarm routing");
	AST_PINS_SAME: assert property ($past(src_a) == SRC_ALARM &&
		$past(src_b) == SRC_ALARM |-> EVENT_PIN_A == EVENT_PIN_B)
		else $error("pins differ with same routing");
	AST_HOLD: assert property (EVENT_PIN_A && !$past(irq_wr) |=>
		EVENT_PIN_A)
		else $error("alarm dropped without a clear");
	AST_W0_KEEP: assert property (EVENT_PIN_A && !$past(irq_wr) &&
		irq_wr && !WDATA[FLAG_BIT] && WDATA[SRCA_LSB+:2] == SRC_ALARM
		|=> s_hold_a)
		else $error("writing zero cleared the alarm");
	AST_ALARM_SET: assert property ($rose(EVENT_PIN_A) &&
		$past(src_a, 2) == SRC_ALARM |->
		SIGNAL_STRENGTH_VALUE > $past(lvl, 2))
		else $error("alarm raised without exceeding level");
	AST_RSSI_RD: assert property (s_rd(OFS_RSSI) |=>
		RDATA == SIGNAL_STRENGTH_VALUE)
		else $error("strength read differs from output");
	AST_RD_IDLE: assert property (!RD |=> RDATA == RD_UNMAP)
		else $error("read data not idle");
endmodule : rssim_checker

// *** dv/rssim_lvl_src.sv ***
module rssim_lvl_src (
	// clock
	input  wire logic       clk,
	// wanted levels
	input  wire logic [7:0] i_want,
	input  wire logic [7:0] q_want,
	// baseband levels
	output logic      [7:0] i_level,
	output logic      [7:0] q_level
);
	timeunit 1ns;
	timeprecision 1ps;
	// amplifier outputs settle just after an edge
	always_ff @(posedge clk) begin
		i_level <= i_want;
		q_level <= q_want;
	end
endmodule : rssim_lvl_src

// *** dv/tb_top.sv ***
module tb_top;
	import rssim_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk, reset_n, wr, rd, cpx_en, pin_a, pin_b;
	logic [3:0]  addr, pbw, lpf, cen;
	logic [7:0]  wdata, rdata, i_lvl, q_lvl, i_tgt, q_tgt, ssv, prev;
	logic [1:0]  gain;
	logic [2:0]  mode;
	logic [31:0] seed = 32'd21625;
	logic [31:0] r;
	int          mismatches, comparisons, n, chg;

	rssim_top u_rssim_top (.SYS_CLK(sys_clk), .RESET_N(reset_n),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.I_LEVEL(i_lvl), .Q_LEVEL(q_lvl), .IF_GAIN_SEL(gain),
		.PASSIVE_BW_SEL(pbw), .LOWPASS_CUTOFF_SEL(lpf),
		.COMPLEX_FILTER_EN(cpx_en), .COMPLEX_CENTER_SEL(cen),
		.OPERATING_MODE_SEL(mode), .SIGNAL_STRENGTH_VALUE(ssv),
		.EVENT_PIN_A(pin_a), .EVENT_PIN_B(pin_b));
	rssim_lvl_src u_rssim_lvl_src (.clk(sys_clk), .i_want(i_tgt),
		.q_want(q_tgt), .i_level(i_lvl), .q_level(q_lvl));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [7:0] env(input logic [7:0] a, b);
		return (a > b) ? a : b;
	endfunction : env

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : bus_wr
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask : rd_chk
	task automatic settle(input int c);
		repeat (c) @(posedge sys_clk);
		#1;
	endtask : settle
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		finish_test();
	end

	initial begin
		reset_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 8'h00;
		i_tgt = 8'h00; q_tgt = 8'h00;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		settle(1);
		chk({6'h00, gain}, 8'h03);
		rd_chk(OFS_MODE, 8'h18);
		rd_chk(OFS_CPLX, 8'h18);
		rd_chk(OFS_DEV, DEV_RST);
		rd_chk(4'h7, RD_UNMAP);
		for (int g = 0; g < 4; g++) begin
			bus_wr(OFS_MODE, 8'(g << GAIN_LSB));
			settle(1);
			chk({6'h00, gain}, 8'(g));
			rd_chk(OFS_MODE, 8'(g << GAIN_LSB));
		end
		repeat (8) begin
			r = xs();
			bus_wr(OFS_FILT, r[7:0]);
			bus_wr(OFS_CPLX, r[15:8]);
			settle(1);
			chk({pbw, lpf}, r[7:0]);
			chk({7'h00, cpx_en}, {7'h00, r[15]});
			chk({4'h0, cen}, {4'h0, r[14:11]});
			rd_chk(OFS_CPLX, r[15:8] & 8'hF8);
		end
		bus_wr(OFS_CPLX, 8'h98);
		bus_wr(OFS_DEV, 8'h03);
		bus_wr(OFS_MODE, {MODE_RX, GAIN_0DB, 3'h0});
		settle(1);
		chk({5'h00, mode}, {5'h00, MODE_RX});
		repeat (5) begin
			r = xs();
			@(posedge sys_clk);
			i_tgt <= r[7:0];
			q_tgt <= r[15:8];
			settle(300);
			chk(ssv, env(r[7:0], r[15:8]));
			rd_chk(OFS_RSSI, env(r[7:0], r[15:8]));
		end
		for (int d = 3; d < 8; d += 4) begin
			bus_wr(OFS_DEV, 8'(d));
			@(posedge sys_clk);
			i_tgt <= 8'h10;
			q_tgt <= 8'h10;
			settle(300);
			@(posedge sys_clk);
			i_tgt <= 8'h40;
			n = 0;
			chg = 0;
			prev = ssv;
			while (ssv !== 8'h40 && n < 400) begin
				settle(1);
				n++;
				if (ssv !== prev) chg++;
				prev = ssv;
			end
			chk({7'h00, n >= 1875 / (2 * (d + 1))
				&& n <= 2000 / (2 * (d + 1)) + 10}, 8'h01);
			chk(8'(chg), 8'h10);
		end
		bus_wr(OFS_LEVEL, 8'h40);
		bus_wr(OFS_IRQ, {SRC_ALARM, SRC_RST, 4'h1});
		settle(50);
		chk({7'h00, pin_a}, 8'h00);
		rd_chk(OFS_IRQ, 8'h40);
		@(posedge sys_clk);
		i_tgt <= 8'h41;
		n = 0;
		while (pin_a !== 1'b1 && n < 300) begin
			settle(1);
			n++;
		end
		chk({6'h00, pin_a, pin_b}, 8'h02);
		@(posedge sys_clk);
		i_tgt <= 8'h00;
		settle(300);
		chk({7'h00, pin_a}, 8'h01);
		rd_chk(OFS_IRQ, 8'h41);
		bus_wr(OFS_IRQ, 8'h40);
		settle(2);
		chk({7'h00, pin_a}, 8'h01);
		bus_wr(OFS_IRQ, 8'h50);
		settle(1);
		chk({6'h00, pin_a, pin_b}, 8'h03);
		bus_wr(OFS_IRQ, 8'hB0);
		settle(1);
		chk({6'h00, pin_a, pin_b}, 8'h00);
		rd_chk(OFS_IRQ, 8'hB1);
		bus_wr(OFS_IRQ, 8'h51);
		settle(1);
		chk({6'h00, pin_a, pin_b}, 8'h00);
		finish_test();
	end
endmodule : tb_top

bind rssim_top rssim_checker u_rssim_checker (.SYS_CLK(SYS_CLK),
	.RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .IF_GAIN_SEL(IF_GAIN_SEL),
	.PASSIVE_BW_SEL(PASSIVE_BW_SEL), .LOWPASS_CUTOFF_SEL(LOWPASS_CUTOFF_SEL),
	.COMPLEX_FILTER_EN(COMPLEX_FILTER_EN),
	.COMPLEX_CENTER_SEL(COMPLEX_CENTER_SEL),
	.SIGNAL_STRENGTH_VALUE(SIGNAL_STRENGTH_VALUE),
	.EVENT_PIN_A(EVENT_PIN_A), .EVENT_PIN_B(EVENT_PIN_B));
